// file: rtl/dsl_lock_detect.sv
`timescale 1ns/100ps
module dsl_lock_detect #(
  parameter int GOOD_CYCLES = dsl_pkg::LOCK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pd_cycle,
  input wire logic [dsl_pkg::ERR_W-1:0] pd_error_ns,
  output logic lock
);
  if (GOOD_CYCLES < 1 || GOOD_CYCLES > 7) begin : g_chk
    $error("good cycle count out of range");
  end
  logic [2:0] good_r;
  logic lock_r;
  // count good compare cycles, drop on a bad one
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      good_r <= 3'h0;
      lock_r <= 1'b0;
    end else if (pd_cycle) begin
      if (lock_r) begin
        good_r <= 3'h0;
        if (pd_error_ns > dsl_pkg::LOCK_EXIT_NS) lock_r <= 1'b0;
      end else if (pd_error_ns < dsl_pkg::LOCK_ENTER_NS) begin
        if (good_r == 3'(GOOD_CYCLES - 1)) begin
          lock_r <= 1'b1;
          good_r <= 3'h0;
        end else begin
          good_r <= good_r + 3'h1;
        end
      end else begin
        good_r <= 3'h0;
      end
    end
  end
  assign lock = lock_r;
  lock_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(lock_r) |-> $past(pd_cycle) && $past(pd_error_ns) < dsl_pkg::LOCK_ENTER_NS)
    else $error("lock set without a good cycle");
  lock_drop_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(lock_r) |-> $past(pd_cycle) && $past(pd_error_ns) > dsl_pkg::LOCK_EXIT_NS)
    else $error("lock dropped without a bad cycle");
  lock_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    lock_r && !(pd_cycle && pd_error_ns > dsl_pkg::LOCK_EXIT_NS) |=> lock_r)
    else $error("lock dropped early");
endmodule : dsl_lock_detect

// file: rtl/dsl_pkg.sv
package dsl_pkg;
  // ---------------------------------------------------------------
  // word, sections, selects
  // ---------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int SEC_N = 2;
  localparam int ERR_W = 8;
  localparam logic [1:0] SEL_IF_REF = 2'h0;
  localparam logic [1:0] SEL_IF_FB = 2'h1;
  localparam logic [1:0] SEL_RF_REF = 2'h2;
  localparam logic [1:0] SEL_RF_FB = 2'h3;
  localparam logic [23:0] LATCH_RST = 24'h000000;
  localparam logic [2:0] PUMP_MAX = 3'h7;
  // lock detect thresholds in ns and good cycles needed
  localparam logic [7:0] LOCK_ENTER_NS = 8'h0f;
  localparam logic [7:0] LOCK_EXIT_NS = 8'h19;
  localparam int LOCK_CYCLES = 3;
  // status mux codes, {rf sel, if sel}
  localparam logic [3:0] MUX_LOW = 4'h0;
  localparam logic [3:0] MUX_IF_ALD = 4'h1;
  localparam logic [3:0] MUX_IF_RDIV = 4'h2;
  localparam logic [3:0] MUX_IF_NDIV = 4'h3;
  localparam logic [3:0] MUX_RF_ALD = 4'h4;
  localparam logic [3:0] MUX_BOTH_ALD = 4'h5;
  localparam logic [3:0] MUX_IF_DLD = 4'h6;
  localparam logic [3:0] MUX_HIGH = 4'h7;
  localparam logic [3:0] MUX_RF_RDIV = 4'h8;
  localparam logic [3:0] MUX_RF_NDIV = 4'h9;
  localparam logic [3:0] MUX_TRI = 4'ha;
  localparam logic [3:0] MUX_IF_CRST = 4'hb;
  localparam logic [3:0] MUX_RF_CRST = 4'hc;
  localparam logic [3:0] MUX_BOTH_CRST = 4'hd;
  localparam logic [3:0] MUX_RF_DLD = 4'he;
  localparam logic [3:0] MUX_BOTH_DLD = 4'hf;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] current;
    logic [1:0] mux_sel;
    logic tristate;
    logic polarity;
    logic [14:0] divide;
    logic [1:0] sel;
  } dsl_ref_latch_t;
  typedef struct packed {
    logic gain;
    logic sleep;
    logic [1:0] presc;
    logic [11:0] main_cnt;
    logic [5:0] swallow;
    logic [1:0] sel;
  } dsl_fb_latch_t;
  typedef struct packed {
    logic [2:0] current;
    logic polarity;
    logic tristate;
  } dsl_pump_t;
  typedef enum logic [2:0] {
    SLP_AWAKE = 3'h1,
    SLP_PUMP_OFF = 3'h2,
    SLP_ASLEEP = 3'h4
  } dsl_sleep_t;
  // prescaler field to base modulus p of p/p+1
  function automatic logic [6:0] modulus_of(logic [1:0] f);
    return 7'h08 << f;
  endfunction : modulus_of
  // counter reset mode hits section sec
  function automatic logic crst_of(logic [3:0] code, logic sec);
    return code == MUX_BOTH_CRST || code == (sec ? MUX_RF_CRST : MUX_IF_CRST);
  endfunction : crst_of
endpackage : dsl_pkg

// file: rtl/dsl_section_divider.sv
`timescale 1ns/100ps
module dsl_section_divider #(
  parameter int REF_W = 15,
  parameter int MAIN_W = 12,
  parameter int SWAL_W = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hold,
  input wire logic ref_tick,
  input wire logic presc_tick,
  input wire logic [REF_W-1:0] ref_div,
  input wire logic [MAIN_W-1:0] main_cnt,
  input wire logic [SWAL_W-1:0] swallow,
  output logic ref_out,
  output logic fb_out,
  output logic modulus_hi
);
  if (SWAL_W > MAIN_W) begin : g_chk
    $error("swallow counter wider than main counter");
  end
  logic [REF_W-1:0] ref_cnt_r;
  logic [MAIN_W-1:0] fb_cnt_r;
  logic [MAIN_W-1:0] fb_cnt_nxt;
  logic ref_out_r, fb_out_r, mod_r;
  wire logic [MAIN_W-1:0] swal_ext = {{(MAIN_W - SWAL_W){1'b0}}, swallow};
  assign fb_cnt_nxt = ({1'b0, fb_cnt_r} + 1'b1 >= {1'b0, main_cnt}) ? '0 : fb_cnt_r + 1'b1;
  // both counters cleared together so they restart aligned
  always_ff @(posedge clk) begin
    if (!rst_b || hold) begin
      ref_cnt_r <= '0;
      fb_cnt_r <= '0;
      ref_out_r <= 1'b0;
      fb_out_r <= 1'b0;
      mod_r <= swallow != '0;
    end else begin
      ref_out_r <= 1'b0;
      fb_out_r <= 1'b0;
      if (ref_tick) begin
        if ({1'b0, ref_cnt_r} + 1'b1 >= {1'b0, ref_div}) begin
          ref_cnt_r <= '0;
          ref_out_r <= 1'b1;
        end else begin
          ref_cnt_r <= ref_cnt_r + 1'b1;
        end
      end
      // n = b*p + a: a cycles at p+1, the rest at p
      if (presc_tick) begin
        fb_cnt_r <= fb_cnt_nxt;
        fb_out_r <= fb_cnt_nxt == '0;
        mod_r <= fb_cnt_nxt < swal_ext;
      end
    end
  end
  assign ref_out = ref_out_r;
  assign fb_out = fb_out_r;
  assign modulus_hi = mod_r;
  align_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(hold) |-> ref_cnt_r == '0 && fb_cnt_r == '0)
    else $error("counters not aligned at release");
endmodule : dsl_section_divider

// file: rtl/dsl_serial_latches.sv
`timescale 1ns/100ps
module dsl_serial_latches (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic [1:0] pd_cycle,
  input wire logic [1:0][dsl_pkg::ERR_W-1:0] pd_error_ns,
  input wire logic [1:0] ref_tick,
  input wire logic [1:0] presc_tick,
  output dsl_pkg::dsl_pump_t [1:0] pump,
  output logic [1:0][6:0] presc_modulus,
  output logic [1:0] modulus_hi,
  output logic [1:0] powered_down,
  output logic [1:0] digital_lock,
  output logic status_mux_out,
  output logic status_mux_oe
);
  // ---------------------------------------------------------------
  // serial link domain
  // ---------------------------------------------------------------
  logic [dsl_pkg::WORD_W-1:0] shift_r;
  // msb first, so each new bit enters at the bottom
  always_ff @(posedge serial_clk) begin
    shift_r <= {shift_r[dsl_pkg::WORD_W-2:0], serial_data};
  end

  // ---------------------------------------------------------------
  // load strobe crossing
  // ---------------------------------------------------------------
  logic ld_meta_r, ld_sync_r, ld_prev_r;
  logic ld_rise;
  logic [1:0] ld_fb;
  dsl_pkg::dsl_fb_latch_t word_fb;
  // serial clock is idle while the strobe is high, so the word is stable
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ld_meta_r <= 1'b0;
      ld_sync_r <= 1'b0;
      ld_prev_r <= 1'b0;
    end else begin
      ld_meta_r <= load_strobe;
      ld_sync_r <= ld_meta_r;
      ld_prev_r <= ld_sync_r;
    end
  end
  assign ld_rise = ld_sync_r && !ld_prev_r;
  assign word_fb = dsl_pkg::dsl_fb_latch_t'(shift_r);
  assign ld_fb[0] = ld_rise && shift_r[1:0] == dsl_pkg::SEL_IF_FB;
  assign ld_fb[1] = ld_rise && shift_r[1:0] == dsl_pkg::SEL_RF_FB;

  // ---------------------------------------------------------------
  // four latches, index 0 if, 1 rf
  // ---------------------------------------------------------------
  dsl_pkg::dsl_ref_latch_t ref_latch_r [2];
  dsl_pkg::dsl_fb_latch_t fb_latch_r [2];
  // no reset pin on the part, so the bank clears on rst_b
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 2; i++) begin
        ref_latch_r[i] <= dsl_pkg::LATCH_RST;
        fb_latch_r[i] <= dsl_pkg::LATCH_RST;
      end
    end else if (ld_rise) begin
      unique case (shift_r[1:0])
        dsl_pkg::SEL_IF_REF: ref_latch_r[0] <= shift_r;
        dsl_pkg::SEL_IF_FB: fb_latch_r[0] <= shift_r;
        dsl_pkg::SEL_RF_REF: ref_latch_r[1] <= shift_r;
        dsl_pkg::SEL_RF_FB: fb_latch_r[1] <= shift_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // mux code and counter reset modes
  // ---------------------------------------------------------------
  logic [3:0] mux_code;
  logic [1:0] crst;
  logic [1:0] hold;
  assign mux_code = {ref_latch_r[1].mux_sel, ref_latch_r[0].mux_sel};

  // ---------------------------------------------------------------
  // power-down sequence
  // ---------------------------------------------------------------
  dsl_pkg::dsl_sleep_t sleep_r [2];
  // pump goes off first unless it was already three-stated
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 2; i++) begin
        sleep_r[i] <= dsl_pkg::SLP_AWAKE;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ld_fb[i]) begin
          if (!word_fb.sleep) begin
            sleep_r[i] <= dsl_pkg::SLP_AWAKE;
          end else if (ref_latch_r[i].tristate) begin
            sleep_r[i] <= dsl_pkg::SLP_ASLEEP;
          end else begin
            sleep_r[i] <= dsl_pkg::SLP_PUMP_OFF;
          end
        end else begin
          unique case (sleep_r[i])
            dsl_pkg::SLP_AWAKE: sleep_r[i] <= dsl_pkg::SLP_AWAKE;
            dsl_pkg::SLP_PUMP_OFF: begin
              if (pd_cycle[i]) sleep_r[i] <= dsl_pkg::SLP_ASLEEP;
            end
            dsl_pkg::SLP_ASLEEP: sleep_r[i] <= dsl_pkg::SLP_ASLEEP;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // pump controls and prescaler outputs
  // ---------------------------------------------------------------
  // gain bit overrides the programmed current
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 2; i++) begin
        pump[i] <= '{current: 3'h0, polarity: 1'b0, tristate: 1'b1};
        presc_modulus[i] <= 7'h08;
        powered_down[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        pump[i].current <= fb_latch_r[i].gain ? dsl_pkg::PUMP_MAX
                                              : ref_latch_r[i].current;
        pump[i].polarity <= ref_latch_r[i].polarity;
        pump[i].tristate <= ref_latch_r[i].tristate || crst[i]
                            || sleep_r[i] != dsl_pkg::SLP_AWAKE;
        presc_modulus[i] <= dsl_pkg::modulus_of(fb_latch_r[i].presc);
        powered_down[i] <= sleep_r[i] == dsl_pkg::SLP_ASLEEP;
      end
    end
  end

  // ---------------------------------------------------------------
  // per section dividers and lock detectors
  // ---------------------------------------------------------------
  logic [1:0] ref_div_p;
  logic [1:0] fb_div_p;
  for (genvar s = 0; s < 2; s++) begin : g_sec
    assign crst[s] = dsl_pkg::crst_of(mux_code, 1'(s));
    assign hold[s] = crst[s] || sleep_r[s] == dsl_pkg::SLP_ASLEEP;
    dsl_section_divider #(
      .REF_W(15),
      .MAIN_W(12),
      .SWAL_W(6)
    ) u_div (
      .clk(clk),
      .rst_b(rst_b),
      .hold(hold[s]),
      .ref_tick(ref_tick[s]),
      .presc_tick(presc_tick[s]),
      .ref_div(ref_latch_r[s].divide),
      .main_cnt(fb_latch_r[s].main_cnt),
      .swallow(fb_latch_r[s].swallow),
      .ref_out(ref_div_p[s]),
      .fb_out(fb_div_p[s]),
      .modulus_hi(modulus_hi[s])
    );
    dsl_lock_detect #(
      .GOOD_CYCLES(dsl_pkg::LOCK_CYCLES)
    ) u_lock (
      .clk(clk),
      .rst_b(rst_b),
      .pd_cycle(pd_cycle[s]),
      .pd_error_ns(pd_error_ns[s]),
      .lock(digital_lock[s])
    );
    fast_cur_a: assert property (@(posedge clk) disable iff (!rst_b)
      fb_latch_r[s].gain |=> pump[s].current == dsl_pkg::PUMP_MAX)
      else $error("gain bit did not force full current");
    crst_tri_a: assert property (@(posedge clk) disable iff (!rst_b)
      crst[s] |=> pump[s].tristate)
      else $error("counter reset left pump driving");
    sleep_async_a: assert property (@(posedge clk) disable iff (!rst_b)
      ld_fb[s] && word_fb.sleep && ref_latch_r[s].tristate
      |=> sleep_r[s] == dsl_pkg::SLP_ASLEEP ##1 powered_down[s])
      else $error("asynchronous sleep not immediate");
    sleep_sync_a: assert property (@(posedge clk) disable iff (!rst_b)
      ld_fb[s] && word_fb.sleep && !ref_latch_r[s].tristate
      |=> sleep_r[s] == dsl_pkg::SLP_PUMP_OFF ##1 pump[s].tristate)
      else $error("synchronous sleep skipped pump off");
  end

  // ---------------------------------------------------------------
  // status mux output
  // ---------------------------------------------------------------
  logic mux_nxt, oe_nxt;
  // analog lock is open drain: release when locked and no compare cycle is active, pull low otherwise
  always_comb begin
    mux_nxt = 1'b0;
    oe_nxt = 1'b1;
    if (fb_latch_r[1].gain) begin
      mux_nxt = 1'b0;
    end else begin
      unique case (mux_code)
        dsl_pkg::MUX_LOW: mux_nxt = 1'b0;
        dsl_pkg::MUX_IF_ALD: oe_nxt = !digital_lock[0] || pd_cycle[0];
        dsl_pkg::MUX_IF_RDIV: mux_nxt = ref_div_p[0];
        dsl_pkg::MUX_IF_NDIV: mux_nxt = fb_div_p[0];
        dsl_pkg::MUX_RF_ALD: oe_nxt = !digital_lock[1] || pd_cycle[1];
        dsl_pkg::MUX_BOTH_ALD: oe_nxt = !(&digital_lock) || (|pd_cycle);
        dsl_pkg::MUX_IF_DLD: mux_nxt = digital_lock[0];
        dsl_pkg::MUX_HIGH: mux_nxt = 1'b1;
        dsl_pkg::MUX_RF_RDIV: mux_nxt = ref_div_p[1];
        dsl_pkg::MUX_RF_NDIV: mux_nxt = fb_div_p[1];
        dsl_pkg::MUX_TRI: oe_nxt = 1'b0;
        dsl_pkg::MUX_IF_CRST, dsl_pkg::MUX_RF_CRST,
        dsl_pkg::MUX_BOTH_CRST: mux_nxt = 1'b0;
        dsl_pkg::MUX_RF_DLD: mux_nxt = digital_lock[1];
        dsl_pkg::MUX_BOTH_DLD: mux_nxt = &digital_lock;
      endcase
    end
  end

  // registered pin drive
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_mux_out <= 1'b0;
      status_mux_oe <= 1'b0;
    end else begin
      status_mux_out <= mux_nxt;
      status_mux_oe <= oe_nxt;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  latch_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
    ld_rise && shift_r[1:0] == dsl_pkg::SEL_RF_FB |=> fb_latch_r[1] == $past(shift_r))
    else $error("rf feedback latch missed its word");
  latch_sleep_a: assert property (@(posedge clk) disable iff (!rst_b)
    powered_down[0] && ld_rise && shift_r[1:0] == dsl_pkg::SEL_IF_REF
    |=> ref_latch_r[0] == $past(shift_r))
    else $error("latch ignored while asleep");
  fastlock_mux_a: assert property (@(posedge clk) disable iff (!rst_b)
    fb_latch_r[1].gain |=> status_mux_oe && !status_mux_out)
    else $error("fast acquire did not ground the output");
  both_lock_a: assert property (@(posedge clk) disable iff (!rst_b)
    mux_code == dsl_pkg::MUX_BOTH_ALD && !fb_latch_r[1].gain && digital_lock != 2'h3
    |=> status_mux_oe && !status_mux_out)
    else $error("combined lock shown with one loop unlocked");
  // a load aimed elsewhere must leave the if reference latch alone
  latch_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    ld_rise && shift_r[1:0] != dsl_pkg::SEL_IF_REF |=> ref_latch_r[0] == $past(ref_latch_r[0]))
    else $error("unselected latch changed");
  // locked loop with analog lock selected releases the pin to its pull-up
  rf_alock_a: assert property (@(posedge clk) disable iff (!rst_b)
    mux_code == dsl_pkg::MUX_RF_ALD && !fb_latch_r[1].gain && digital_lock[1] && !pd_cycle[1]
    |=> !status_mux_oe)
    else $error("analog lock not released while locked");
endmodule : dsl_serial_latches

// file: tb/dsl_host_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// host side of the three-wire serial port
// ---------------------------------------------------------------
module dsl_host_model (
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe
);
  // idle: serial clock stands still, strobe low
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end
  // shift one word msb first, then pulse the load strobe
  task automatic send_word(input logic [23:0] w);
    #37;
    for (int i = 23; i >= 0; i--) begin
      serial_data = w[i];
      #80 serial_clk = 1'b1;
      #80 serial_clk = 1'b0;
    end
    // released data line must not keep the last bit
    serial_data = ~w[0];
    #80 load_strobe = 1'b1;
    #200 load_strobe = 1'b0;
    #200;
  endtask : send_word
endmodule : dsl_host_model

// file: tb/dsl_serial_latches_tb.sv
`timescale 1ns/100ps
module dsl_serial_latches_tb;
  typedef struct {
    logic [23:0] word;
    logic sec;
    dsl_pkg::dsl_pump_t pump;
    logic [6:0] modulus;
  } dsl_row_t;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] pd_cycle = 2'h0;
  logic [1:0][dsl_pkg::ERR_W-1:0] pd_error_ns = 16'h0000;
  logic [1:0] ref_tick = 2'h0;
  logic [1:0] presc_tick = 2'h0;
  logic serial_clk;
  logic serial_data;
  logic load_strobe;
  dsl_pkg::dsl_pump_t [1:0] pump;
  logic [1:0][6:0] presc_modulus;
  logic [1:0] modulus_hi;
  logic [1:0] powered_down;
  logic [1:0] digital_lock;
  logic status_mux_out;
  logic status_mux_oe;
  int mismatches = 0;
  int checks = 0;
  dsl_row_t rows [7];
  dsl_pkg::dsl_pump_t exp_p [2];
  logic [6:0] exp_m [2];
  logic [7:0] mux_tab [9] = '{8'h08, 8'h18, 8'ha0, 8'hba, 8'hc9, 8'hdb, 8'h58, 8'he8, 8'h7c};
  logic [8:0] lock_tab [8] = '{9'h00e, 9'h00e, 9'h00f, 9'h00e, 9'h00e, 9'h10e, 9'h119, 9'h01a};
  // 20 MHz system clock
  always #25 clk = ~clk;
  dsl_host_model i_host (
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .load_strobe(load_strobe)
  );
  dsl_serial_latches i_dut (
    .clk(clk), .rst_b(rst_b), .serial_clk(serial_clk), .serial_data(serial_data),
    .load_strobe(load_strobe), .pd_cycle(pd_cycle), .pd_error_ns(pd_error_ns),
    .ref_tick(ref_tick), .presc_tick(presc_tick), .pump(pump),
    .presc_modulus(presc_modulus), .modulus_hi(modulus_hi), .powered_down(powered_down),
    .digital_lock(digital_lock), .status_mux_out(status_mux_out),
    .status_mux_oe(status_mux_oe)
  );
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic wr(input logic [23:0] w);
    step(1);
    i_host.send_word(w);
  endtask : wr
  function automatic logic [23:0] ref_w(logic [2:0] cur, logic [1:0] mux, logic tris,
                                        logic pol, logic rf);
    return {cur, mux, tris, pol, 15'h0041, rf, 1'b0};
  endfunction : ref_w
  function automatic logic [23:0] fb_w(logic gain, logic slp, logic [1:0] presc, logic rf);
    return {gain, slp, presc, 12'h00a, 6'h05, rf, 1'b1};
  endfunction : fb_w
  task automatic reset_dut;
    rst_b = 1'b0;
    step(2);
    rst_b = 1'b1;
    step(2);
    for (int s = 0; s < 2; s++) begin
      exp_p[s] = 5'h00;
      exp_m[s] = 7'h08;
      chk(presc_modulus[s] === 7'h08 && pump[s] === 5'h00, "reset latches");
      chk(powered_down[s] === 1'b0 && digital_lock[s] === 1'b0, "reset state");
    end
    chk(status_mux_oe === 1'b1 && status_mux_out === 1'b0, "reset mux");
    $display("test reset done");
  endtask : reset_dut
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // hang guard
  initial begin
    #1000000;
    mismatches++;
    end_of_test();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] m;
    logic [7:0] n;
    rows[0] = '{ref_w(3'h5, 2'h0, 1'b0, 1'b1, 1'b0), 1'b0, 5'h16, 7'h08};
    rows[1] = '{ref_w(3'h3, 2'h0, 1'b1, 1'b0, 1'b1), 1'b1, 5'h0d, 7'h08};
    rows[2] = '{fb_w(1'b0, 1'b0, 2'h1, 1'b0), 1'b0, 5'h16, 7'h10};
    rows[3] = '{fb_w(1'b0, 1'b0, 2'h2, 1'b1), 1'b1, 5'h0d, 7'h20};
    rows[4] = '{fb_w(1'b1, 1'b0, 2'h3, 1'b0), 1'b0, 5'h1e, 7'h40};
    rows[5] = '{fb_w(1'b0, 1'b0, 2'h0, 1'b0), 1'b0, 5'h16, 7'h08};
    rows[6] = '{ref_w(3'h6, 2'h0, 1'b0, 1'b1, 1'b1), 1'b1, 5'h1a, 7'h20};
    reset_dut();
    // all four latches written, each section checked after every load
    foreach (rows[i]) begin
      wr(rows[i].word);
      exp_p[rows[i].sec] = rows[i].pump;
      exp_m[rows[i].sec] = rows[i].modulus;
      for (int s = 0; s < 2; s++) begin
        chk(pump[s] === exp_p[s], "pump fields");
        chk(presc_modulus[s] === exp_m[s], "prescaler modulus");
        chk(status_mux_oe === 1'b1 && status_mux_out === 1'b0, "mux low");
      end
    end
    $display("test rows done");
    // status mux codes and counter reset modes
    foreach (mux_tab[i]) begin
      m = mux_tab[i];
      wr(ref_w(3'h5, m[5:4], 1'b0, 1'b1, 1'b0));
      wr(ref_w(3'h6, m[7:6], 1'b0, 1'b1, 1'b1));
      chk(status_mux_oe === m[3] && (!m[3] || status_mux_out === m[2]), "mux out");
      chk(pump[0].tristate === m[1] && pump[1].tristate === m[0], "reset mode");
    end
    $display("test mux done");
    // rf gain bit overrides the mux and raises current
    wr(fb_w(1'b1, 1'b0, 2'h2, 1'b1));
    chk(status_mux_oe === 1'b1 && status_mux_out === 1'b0, "fast acquire");
    chk(pump[1].current === dsl_pkg::PUMP_MAX, "gain current");
    wr(fb_w(1'b0, 1'b0, 2'h2, 1'b1));
    chk(status_mux_out === 1'b1 && pump[1].current === 3'h6, "fast acquire end");
    $display("test fast acquire done");
    // two whole main count periods hold twice the swallow count
    for (int s = 0; s < 2; s++) begin
      n = 8'h00;
      repeat (20) begin
        presc_tick = 2'h3;
        ref_tick = 2'h3;
        step(1);
        presc_tick = 2'h0;
        ref_tick = 2'h0;
        step(2);
        n = n + modulus_hi[s];
      end
      chk(n === 8'h0a, "swallow count");
    end
    $display("test divider done");
    // lock detect on the rf section
    foreach (lock_tab[i]) begin
      pd_error_ns[1] = lock_tab[i][7:0];
      pd_cycle = 2'h2;
      step(1);
      pd_cycle = 2'h0;
      step(1);
      chk(digital_lock[1] === lock_tab[i][8], "digital lock");
    end
    $display("test lock done");
    // sleep without tristate goes through pump off first
    wr(fb_w(1'b0, 1'b1, 2'h0, 1'b0));
    chk(pump[0].tristate === 1'b1 && powered_down[0] === 1'b0, "pump off first");
    pd_cycle = 2'h1;
    step(1);
    pd_cycle = 2'h0;
    step(2);
    chk(powered_down[0] === 1'b1, "asleep after compare");
    wr(fb_w(1'b0, 1'b0, 2'h1, 1'b0));
    chk(powered_down[0] === 1'b0 && presc_modulus[0] === 7'h10, "wake and load");
    wr(ref_w(3'h6, 2'h1, 1'b1, 1'b1, 1'b1));
    wr(fb_w(1'b0, 1'b1, 2'h2, 1'b1));
    chk(powered_down[1] === 1'b1, "immediate sleep");
    $display("test power down done");
    reset_dut();
    end_of_test();
  end
endmodule : dsl_serial_latches_tb
